/* shared/psbo_pkg.sv */
package psbo_pkg;

   // Pixel depth selection codes.
   typedef enum logic [1:0] {
      PSBO_BPP16 = 2'b00,
      PSBO_BPP18 = 2'b01,
      PSBO_BPP24 = 2'b10
   } psbo_bpp_t;

   // Incoming pixel word: 8 bits per colour, narrower depths use the top bits.
   typedef struct packed {
      logic [7:0] red;
      logic [7:0] green;
      logic [7:0] blue;
   } psbo_pixel_t;

   localparam int PSBO_BUF_DEPTH  = 2;
   localparam int PSBO_BIT_CNT_W  = 3;
   localparam int PSBO_ACC_W      = 32;
   localparam int PSBO_LVL_W      = 6;
   localparam logic [2:0] PSBO_LAST_BIT = 3'h7;
   localparam logic [5:0] PSBO_LVL_BYTE = 6'h08;
   localparam logic [5:0] PSBO_LVL_16   = 6'h10;
   localparam logic [5:0] PSBO_LVL_18   = 6'h12;
   localparam logic [5:0] PSBO_LVL_24   = 6'h18;

endpackage

/* rtl/psbo_byte_order.sv */
`timescale 1ns/1ps

module psbo_byte_order
   import psbo_pkg::*;
(
   input  wire logic        sys_clk_in,
   input  wire logic        rst_b_in,
   input  wire psbo_bpp_t   bpp_sel_in,
   input  wire logic        byte_order_select_in,
   input  wire logic        rgb_swap_select_in,
   input  wire psbo_pixel_t pix_data_in,
   input  wire logic        pix_valid_in,
   output logic             pix_ready_out,
   output logic             ser_data_out,
   output logic             ser_valid_out,
   input  wire logic        ser_ready_in,
   output logic             ser_byte_start_out
);

   ////////////////////////////////////////////////////////////////////////////
   // State.

   // All state lives in one packed struct: buffer, accumulator and serialiser.
   // The accumulator holds the bits that wait for the shift register, first bit
   // at its top, and level counts them.
   typedef struct packed {
      logic [PSBO_BUF_DEPTH-1:0][23:0] buf_data;
      logic [PSBO_BUF_DEPTH-1:0][5:0]  buf_len;
      logic                            wr_ptr;
      logic                            rd_ptr;
      logic [1:0]                      count;
      logic [PSBO_ACC_W-1:0]           acc;
      logic [PSBO_LVL_W-1:0]           level;
      logic [7:0]                      shreg;
      logic [PSBO_BIT_CNT_W-1:0]       bit_cnt;
      logic                            busy;
      logic                            ser_bit;
      logic                            ser_start;
   } psbo_state_t;

   psbo_state_t state_q;
   psbo_state_t state_d;

   ////////////////////////////////////////////////////////////////////////////
   // Arrangement of one pixel into a left-aligned bit string, first bit at the
   // top. Returns the string; its length follows from the depth.
   // Narrower depths use the upper bits of each colour, and the unused tail of
   // the string stays zero so that it can be ORed into the accumulator.

   function automatic logic [23:0] psbo_arrange(input psbo_pixel_t p,
                                                input psbo_bpp_t   bpp,
                                                input logic        ord,
                                                input logic        swp);
      logic [4:0]  r5;
      logic [5:0]  g6;
      logic [4:0]  b5;
      logic [23:0] res;
      r5  = p.red[7:3];
      g6  = p.green[7:2];
      b5  = p.blue[7:3];
      res = 24'h000000;
      case (bpp)
         PSBO_BPP16: begin
            case ({ord, swp})
               2'b10:   res = {r5, g6, b5, 8'h00};
               2'b00:   res = {g6[2:0], b5, r5, g6[5:3], 8'h00};
               2'b11:   res = {b5, g6, r5, 8'h00};
               default: res = {g6[2:0], r5, b5, g6[5:3], 8'h00};
            endcase
         end
         PSBO_BPP18: begin
            // Only the swap setting chooses the 18 bpp layout. Order 0 has no
            // layout of its own here and reuses that of order 1, so software
            // must not count on a distinct order 0 packing at this depth.
            if (swp) begin
               res = {p.blue[7:2], p.green[7:2], p.red[7:2], 6'h00};
            end else begin
               res = {p.red[7:2], p.green[7:2], p.blue[7:2], 6'h00};
            end
         end
         default: begin
            case ({ord, swp})
               2'b10:   res = {p.red, p.green, p.blue};
               2'b00:   res = {p.blue, p.green, p.red};
               2'b11:   res = {p.blue, p.green, p.red};
               default: res = {p.red, p.green, p.blue};
            endcase
         end
      endcase
      return res;
   endfunction

   // Number of bits one pixel adds to the stream at the given depth. It is
   // taken when the pixel enters the buffer, so a later depth change cannot
   // misalign the entries that are already waiting.
   function automatic logic [5:0] psbo_len(input psbo_bpp_t bpp);
      logic [5:0] len;
      case (bpp)
         PSBO_BPP16: len = PSBO_LVL_16;
         PSBO_BPP18: len = PSBO_LVL_18;
         default:    len = PSBO_LVL_24;
      endcase
      return len;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Two-entry buffer handshakes.

   logic        buf_push;
   logic        buf_pop;
   logic        room;
   logic [23:0] arranged;

   // The host sees ready while the buffer holds fewer than two pixels. Ready
   // depends on registered state only, never on pix_valid_in, so no
   // combinational loop can form through the host's handshake.
   assign pix_ready_out = (state_q.count != 2'h2);
   assign buf_push      = pix_valid_in && pix_ready_out;
   // The packer takes a pixel only when the accumulator has room for 24 bits,
   // so a stalled receiver backs up into the buffer and then the host.
   assign room     = (state_q.level <= PSBO_LVL_BYTE);
   assign buf_pop  = (state_q.count != 2'h0) && room;
   assign arranged = state_q.buf_data[state_q.rd_ptr];

   ////////////////////////////////////////////////////////////////////////////
   // Next state.

   // Three steps run in a fixed order within one cycle. First the serialiser
   // retires the bit the receiver has just taken. Then, if the shift register
   // is free, the oldest eight accumulated bits move into it, so a new byte
   // starts in the cycle right after the last bit of the one before. Last, a
   // buffered pixel is appended behind whatever bits still wait. Loading before
   // appending keeps the accumulator within its 32 bits: a pixel is appended
   // only when at most eight bits wait, and the load can only lower that, so
   // eight plus the 24 bits of the deepest pixel never overflow. The price is
   // one cycle without a pop when nine to sixteen bits wait.
   always_comb begin
      logic [5:0]  lvl;
      logic [31:0] acc;
      logic [31:0] ins;
      state_d = state_q;
      lvl     = state_q.level;
      acc     = state_q.acc;
      ins     = 32'h00000000;

      if (buf_push) begin
         state_d.buf_data[state_q.wr_ptr] = psbo_arrange(pix_data_in, bpp_sel_in,
                                                         byte_order_select_in,
                                                         rgb_swap_select_in);
         state_d.buf_len[state_q.wr_ptr] = psbo_len(bpp_sel_in);
         state_d.wr_ptr = ~state_q.wr_ptr;
      end
      // Buffer occupancy; a push and a pop in one cycle leave it unchanged.
      state_d.count = state_q.count + {1'b0, buf_push} - {1'b0, buf_pop};

      // Serialiser: one bit a cycle while the receiver accepts.
      // The byte-start pulse lasts one cycle even when the receiver stalls on
      // the first bit, so a listener must latch it together with that bit.
      state_d.ser_start = 1'b0;
      if (state_q.busy && ser_ready_in) begin
         state_d.shreg   = {1'b0, state_q.shreg[7:1]};
         state_d.ser_bit = state_q.shreg[1];
         state_d.bit_cnt = state_q.bit_cnt + 3'h1;
         if (state_q.bit_cnt == PSBO_LAST_BIT) begin
            state_d.busy = 1'b0;
         end
      end

      // Load the next byte from the top of the accumulator once idle.
      // A partial byte at 18 bpp waits here until more pixels arrive; a stream
      // that stops in mid-byte keeps its last bits until then.
      if (!state_d.busy && (lvl >= PSBO_LVL_BYTE)) begin
         state_d.shreg     = acc[31:24];
         state_d.ser_bit   = acc[24];
         state_d.bit_cnt   = 3'h0;
         state_d.busy      = 1'b1;
         state_d.ser_start = 1'b1;
         acc = {acc[23:0], 8'h00};
         lvl = lvl - PSBO_LVL_BYTE;
      end

      // Append the next pixel right behind the bits still waiting.
      if (buf_pop) begin
         ins = {arranged, 8'h00} >> lvl;
         acc = acc | ins;
         lvl = lvl + state_q.buf_len[state_q.rd_ptr];
         state_d.rd_ptr = ~state_q.rd_ptr;
      end
      // Commit the working copies of accumulator and level.
      state_d.acc   = acc;
      state_d.level = lvl;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers.

   // One register for the whole state. The reset loads constants only, which
   // leaves the buffer empty, the accumulator clear and the serial side idle
   // with ready high towards the host.
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         state_q <= '0;
      end else begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs.

   // Data outputs come straight from flip-flops. A stalled receiver sees data
   // and valid hold, since neither changes until ser_ready_in is sampled high.
   assign ser_data_out       = state_q.ser_bit;
   assign ser_valid_out      = state_q.busy;
   assign ser_byte_start_out = state_q.ser_start;

endmodule

/* tb/psbo_byte_order_checker.sv */
`timescale 1ns/1ps
// Watches the serial side: a slip in framing or flow control shows up here first.
module psbo_byte_order_checker
   import psbo_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_b_in,
   input wire logic pix_valid_in,
   input wire logic pix_ready_out,
   input wire logic ser_data_out,
   input wire logic ser_valid_out,
   input wire logic ser_ready_in,
   input wire logic ser_byte_start_out
);
   logic [2:0] cnt_q;
   // Counts accepted bits, so that byte starts can be held against the frame.
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cnt_q <= 3'h0;
      end else if (ser_valid_out && ser_ready_in) begin
         cnt_q <= cnt_q + 3'h1;
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);
   a_bit_stall_hold: assert property (
      ser_valid_out && !ser_ready_in |=> $stable(ser_data_out))
      else $error("serial bit changed while stalled");
   a_valid_stall_hold: assert property (
      ser_valid_out && !ser_ready_in |=> ser_valid_out)
      else $error("serial valid dropped while stalled");
   a_start_aligned: assert property (ser_byte_start_out |-> cnt_q == 3'h0)
      else $error("byte start off the byte boundary");
   a_start_with_bit: assert property (ser_byte_start_out |-> ser_valid_out)
      else $error("byte start without a valid bit");
   a_byte_no_gap: assert property (
      ser_valid_out && ser_ready_in && cnt_q != 3'h7 |=> ser_valid_out)
      else $error("gap inside a byte");
   a_push_to_bits: assert property (
      pix_valid_in && pix_ready_out |-> ##[0:3] ser_valid_out)
      else $error("no serial output after a pixel");
   a_start_on_rise: assert property ($rose(ser_valid_out) |-> ser_byte_start_out)
      else $error("first bit after idle without byte start");
   a_start_after_byte: assert property (
      ser_valid_out && ser_ready_in && cnt_q == 3'h7 ##1 ser_valid_out |-> ser_byte_start_out)
      else $error("next byte without byte start");
endmodule

/* tb/psbo_rx_model.sv */
`timescale 1ns/1ps
// Serial receiver: stalls at random when slow, rebuilds bytes from bits.
module psbo_rx_model (
   input  wire logic  sys_clk_in,
   input  wire logic  rst_b_in,
   input  wire logic  slow_in,
   input  wire logic  ser_data_in,
   input  wire logic  ser_valid_in,
   output logic       ser_ready_out,
   output logic [7:0] rx_byte_out,
   output logic       rx_stb_out
);
   logic [7:0] lf_q;
   logic [7:0] sh_q;
   logic [2:0] cnt_q;
   // The first bit lands at the bottom, so the shift runs toward bit 0.
   always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         {lf_q, sh_q, cnt_q} <= {8'h5a, 8'h00, 3'h0};
         {ser_ready_out, rx_byte_out, rx_stb_out} <= '0;
      end else begin
         rx_stb_out <= 1'b0;
         lf_q <= {lf_q[6:0], lf_q[7] ^ lf_q[5] ^ lf_q[4] ^ lf_q[3]};
         ser_ready_out <= !slow_in || lf_q[0];
         if (ser_valid_in && ser_ready_out) begin
            sh_q <= {ser_data_in, sh_q[7:1]};
            cnt_q <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
               rx_byte_out <= {ser_data_in, sh_q[7:1]};
               rx_stb_out <= 1'b1;
            end
         end
      end
   end
endmodule

/* tb/psbo_byte_order_tb.sv */
`timescale 1ns/1ps
module psbo_byte_order_tb;
   import psbo_pkg::*;
   logic sys_clk_in = 0, rst_b_in = 0, pix_valid_in = 0, slow = 0;
   logic byte_order_select_in = 0, rgb_swap_select_in = 0;
   psbo_bpp_t bpp_sel_in = PSBO_BPP16;
   psbo_pixel_t pix_data_in = '0;
   logic pix_ready_out, ser_data_out, ser_valid_out, ser_ready_in, ser_byte_start_out, rx_stb;
   logic [7:0] rx_byte, lf = 8'h57, expq[$];
   logic bitq[$];
   int failures = 0, check_count = 0;
   always #5 sys_clk_in = ~sys_clk_in;
   psbo_byte_order u_psbo_byte_order (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
      .bpp_sel_in(bpp_sel_in), .byte_order_select_in(byte_order_select_in),
      .rgb_swap_select_in(rgb_swap_select_in), .pix_data_in(pix_data_in),
      .pix_valid_in(pix_valid_in), .pix_ready_out(pix_ready_out), .ser_data_out(ser_data_out),
      .ser_valid_out(ser_valid_out), .ser_ready_in(ser_ready_in),
      .ser_byte_start_out(ser_byte_start_out));
   psbo_rx_model u_psbo_rx_model (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .slow_in(slow),
      .ser_data_in(ser_data_out), .ser_valid_in(ser_valid_out), .ser_ready_out(ser_ready_in),
      .rx_byte_out(rx_byte), .rx_stb_out(rx_stb));
   function logic [7:0] rnd();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction
   task check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task end_sim();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Builds the expected bit string of a pixel, then cuts whole bytes off it.
   task push(input psbo_pixel_t p);
      logic [23:0] s;
      logic [15:0] h;
      logic [7:0] b;
      int n;
      h = rgb_swap_select_in ? {p.blue[7:3], p.green[7:2], p.red[7:3]}
                             : {p.red[7:3], p.green[7:2], p.blue[7:3]};
      if (!byte_order_select_in) h = {h[7:0], h[15:8]};
      case (bpp_sel_in)
         PSBO_BPP16: begin
            s = {h, 8'h00};
            n = 16;
         end
         PSBO_BPP18: begin
            s = {p.red[7:2], p.green[7:2], p.blue[7:2], 6'h00};
            if (rgb_swap_select_in) s = {p.blue[7:2], p.green[7:2], p.red[7:2], 6'h00};
            n = 18;
         end
         default: begin
            s = {p.blue, p.green, p.red};
            if (byte_order_select_in != rgb_swap_select_in) s = p;
            n = 24;
         end
      endcase
      for (int i = 0; i < n; i++) bitq.push_back(s[23-i]);
      while (bitq.size() >= 8) begin
         for (int j = 7; j >= 0; j--) b[j] = bitq.pop_front();
         expq.push_back(b);
      end
      pix_data_in <= p;
      pix_valid_in <= 1'b1;
      do @(posedge sys_clk_in); while (!pix_ready_out);
   endtask
   // Each received byte is held against the oldest expected one.
   // A byte with nothing left to expect is an extra byte and always a mismatch.
   always @(posedge sys_clk_in) begin
      if (rx_stb && expq.size() == 0) begin
         check(rx_byte, ~rx_byte);
      end else if (rx_stb) begin
         check(rx_byte, expq.pop_front());
      end
   end
   // Every ordering mode and depth, with a prompt and a stalling receiver.
   initial begin
      repeat (6) @(posedge sys_clk_in);
      rst_b_in <= 1'b1;
      for (int c = 0; c < 8; c++) for (int d = 0; d < 3; d++) begin
         {slow, rgb_swap_select_in, byte_order_select_in} <= c[2:0];
         bpp_sel_in <= psbo_bpp_t'(d);
         @(posedge sys_clk_in);
         repeat (4) push({rnd(), rnd(), rnd()});
         pix_valid_in <= 1'b0;
         while (expq.size() != 0) @(posedge sys_clk_in);
      end
      end_sim();
   end
   // Cuts a hang short well beyond the expected run length.
   initial begin
      #400000;
      failures++;
      end_sim();
   end
endmodule
bind psbo_byte_order psbo_byte_order_checker u_psbo_byte_order_checker (
   .sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in), .pix_valid_in(pix_valid_in),
   .pix_ready_out(pix_ready_out), .ser_data_out(ser_data_out), .ser_valid_out(ser_valid_out),
   .ser_ready_in(ser_ready_in), .ser_byte_start_out(ser_byte_start_out));
